// ---- hdl/crl_map.svh ----
// Constants of the classifier rule store: geometry, default rules, widths.
// Assumes inclusion by bare name from both ends and from the package.
`ifndef CRL_MAP_SVH
`define CRL_MAP_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define CRL_ADDRS_PER_BLOCK 1024
`define CRL_ENT_W 36
`define CRL_ACT_W 70
`define CRL_ADDR_W 13
`define CRL_MEM_DEPTH 8192
`define CRL_MAX_SPAN 16
`define CRL_MAX_ENT_LOG 3'h4
`define CRL_MAX_ACT_LOG 3'h2

// ------------------------------------------------------------
// Default rules
// ------------------------------------------------------------
`define CRL_DEF_RULES 5'd30
`define CRL_LOOKUPS 2'd3
`define CRL_DEF_BASE0 13'd6144
`define CRL_DEF_BASE1 13'd6624
`define CRL_DEF_BASE2 13'd7104

`endif

// ---- hdl/crl_pkg.sv ----
// Types and type-group helpers shared by both ends of the rule store link.
// Assumes crl_map.svh is on the include path.
`include "crl_map.svh"

package crl_pkg;

  typedef logic [`CRL_ENT_W-1:0] crl_ent_word_type;
  typedef logic [`CRL_ACT_W-1:0] crl_act_word_type;
  typedef logic [`CRL_ADDR_W-1:0] crl_addr_type;
  typedef crl_ent_word_type [`CRL_MAX_SPAN-1:0] crl_key_type;
  typedef enum logic [1:0] {CRL_ENTRY, CRL_ACTION, CRL_COUNTER} crl_kind_type;
  typedef enum {CRL_IDLE, CRL_CMP, CRL_ACT} crl_state_type;

  // Entry type-group width for an offset and log2 of the entry span
  function automatic logic [2:0] crl_etg_w(input logic [3:0] off, input logic [2:0] szl);
    if (off == 4'h0) crl_etg_w = szl + 3'h1;
    else if (off[0]) crl_etg_w = 3'h1;
    else if (off[1]) crl_etg_w = 3'h2;
    else if (off[2]) crl_etg_w = 3'h3;
    else crl_etg_w = 3'h4;
  endfunction

  // Action type-group width for an offset and log2 of the action span
  function automatic logic [2:0] crl_atg_w(input logic [1:0] off, input logic [2:0] szl);
    if (off == 2'h0) crl_atg_w = szl + 3'h1;
    else if (off[0]) crl_atg_w = 3'h1;
    else crl_atg_w = 3'h2;
  endfunction

  // Type-group value: one-hot size at offset zero, zero elsewhere
  function automatic logic [4:0] crl_tg_val(input logic [3:0] off, input logic [2:0] szl);
    crl_tg_val = (off == 4'h0) ? (5'h01 << szl) : 5'h00;
  endfunction

endpackage

// ---- hdl/crl_if.sv ----
// Link between the rule store and the party that programs it and submits keys.
// Assumes both ends share mclk; the interface carries no clock.
interface crl_if;
  import crl_pkg::*;

  logic [2:0] blocks;
  logic prog_valid;
  logic prog_rd;
  crl_kind_type prog_kind;
  crl_addr_type prog_addr;
  crl_ent_word_type prog_entry;
  crl_ent_word_type prog_mask;
  crl_act_word_type prog_action;
  logic prog_cnt;
  logic rd_valid;
  crl_ent_word_type rd_entry;
  crl_ent_word_type rd_mask;
  crl_act_word_type rd_action;
  logic rd_cnt;
  logic key_valid;
  logic key_ready;
  crl_key_type key_words;
  logic [2:0] key_szl;
  logic [1:0] key_lookup;
  logic [4:0] key_default;
  logic res_valid;
  logic res_last;
  logic res_hit;
  crl_addr_type res_addr;
  crl_act_word_type res_action;

  modport dev (
    input blocks, prog_valid, prog_rd, prog_kind, prog_addr, prog_entry, prog_mask,
    input prog_action, prog_cnt, key_valid, key_words, key_szl, key_lookup, key_default,
    output rd_valid, rd_entry, rd_mask, rd_action, rd_cnt, key_ready,
    output res_valid, res_last, res_hit, res_addr, res_action
  );

  modport host (
    output blocks, prog_valid, prog_rd, prog_kind, prog_addr, prog_entry, prog_mask,
    output prog_action, prog_cnt, key_valid, key_words, key_szl, key_lookup, key_default,
    input rd_valid, rd_entry, rd_mask, rd_action, rd_cnt, key_ready,
    input res_valid, res_last, res_hit, res_addr, res_action
  );
endinterface

// ---- hdl/crl_store.sv ----
// Ternary rule store of one classification lookup stage: entries, masks,
// actions and one-bit hit counters, with a sequential matcher.
// Assumes the far end inserts type-group fields and zero masks over them.
`include "crl_map.svh"

// Function
// - Each assigned block adds 1024 rule addresses
// - Words hold 36 entry, 70 action bits
// - Hit counter is one bit, saturating
// - Entries span 1, 2, 4, 8, 16
// - Actions span 1, 2, 4 with type-group
// - Entry offset zero holds one-hot size
// - Odd entry offsets hold one zero bit
// - Entry offsets 2,6,10,14 hold two zeros
// - Entry offsets 4,12 hold three zeros
// - Entry offset 8 holds four zeros
// - Action offset zero holds one-hot size
// - Action offsets 1,3 hold one zero
// - Action offset 2 holds two zeros
// - Default rule chosen only when nothing matches
// - No blocks assigned means default always
// - First lookup defaults at 6144 plus 16n
// - Second lookup defaults at 6624 plus 16n
// - Third lookup defaults at 7104 plus 16n
// - Span-n rules start at multiples of n
// - Only the offset-zero counter is set
// - Type-group sits in the low bits
// - Mask bits over type-group are zero
module crl_store #(
  parameter int DEPTH = `CRL_MEM_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Link to the programming and key-submitting party
  crl_if.dev link,
  // Status
  output logic lookup_busy_q
);
  import crl_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Contents are undefined after reset; software must initialise them
  crl_ent_word_type ent_mem [DEPTH];
  crl_ent_word_type msk_mem [DEPTH];
  crl_act_word_type act_mem [DEPTH];
  logic cnt_mem [DEPTH];

  crl_state_type state_q;
  crl_key_type key_q;
  logic [2:0] szl_q;
  logic [1:0] lk_q, aoff_q;
  logic [4:0] def_q;
  logic [13:0] lim_q, base_q;
  logic [3:0] off_q;
  logic hit_q, cnt_set_q, key_ready_q, res_valid_q, res_last_q, res_hit_q, rd_valid_q, rd_cnt_q;
  crl_addr_type hit_addr_q, res_addr_q;
  crl_act_word_type res_action_q, rd_action_q;
  crl_ent_word_type rd_entry_q, rd_mask_q;

  logic [13:0] span, nxt_base;
  crl_addr_type cur_addr, def_addr, act_addr;
  crl_ent_word_type key_word;
  logic ent_hit;
  logic [2:0] alen;
  logic [1:0] alast;

  // ------------------------------------------------------------
  // Programming and readback
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (link.prog_valid && link.prog_kind == CRL_ENTRY) begin
      ent_mem[link.prog_addr] <= link.prog_entry;
      msk_mem[link.prog_addr] <= link.prog_mask;
    end
    if (link.prog_valid && link.prog_kind == CRL_ACTION) begin
      act_mem[link.prog_addr] <= link.prog_action;
    end
  end

  // A hit set is written last so it wins over a same-cycle clear
  always_ff @(posedge mclk) begin
    if (link.prog_valid && link.prog_kind == CRL_COUNTER) begin
      cnt_mem[link.prog_addr] <= link.prog_cnt;
    end
    if (cnt_set_q) begin
      cnt_mem[hit_addr_q] <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid_q <= 1'b0;
      rd_entry_q <= '0;
      rd_mask_q <= '0;
      rd_action_q <= '0;
      rd_cnt_q <= 1'b0;
    end else begin
      rd_valid_q <= link.prog_rd;
      if (link.prog_rd) begin
        rd_entry_q <= ent_mem[link.prog_addr];
        rd_mask_q <= msk_mem[link.prog_addr];
        rd_action_q <= act_mem[link.prog_addr];
        rd_cnt_q <= cnt_mem[link.prog_addr];
      end
    end
  end

  // ------------------------------------------------------------
  // Match datapath
  // ------------------------------------------------------------
  always_comb begin
    span = 14'h0001 << szl_q;
    nxt_base = base_q + span;
    cur_addr = base_q[`CRL_ADDR_W-1:0] + {9'h000, off_q};
    // Key words carry no type-group; it is inserted here
    key_word = (key_q[off_q] << crl_etg_w(off_q, szl_q))
      | {31'h0, crl_tg_val(off_q, szl_q)};
    // Mask one is don't-care; type-group bits carry mask zero
    ent_hit = ((ent_mem[cur_addr] ^ key_word) & ~msk_mem[cur_addr]) == '0;
    case (lk_q)
      2'd0: def_addr = `CRL_DEF_BASE0;
      2'd1: def_addr = `CRL_DEF_BASE1;
      default: def_addr = `CRL_DEF_BASE2;
    endcase
    def_addr = def_addr + {4'h0, def_q, 4'h0};
    // Action size comes from the offset-zero action type-group
    if (act_mem[hit_addr_q][0]) alen = 3'h0;
    else if (act_mem[hit_addr_q][1]) alen = 3'h1;
    else alen = 3'h2;
    alast = 2'((3'h1 << alen) - 3'h1);
    act_addr = hit_addr_q + {11'h000, aoff_q};
  end

  // ------------------------------------------------------------
  // Lookup engine
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= CRL_IDLE;
      key_q <= '0;
      szl_q <= 3'h0;
      lk_q <= 2'h0;
      def_q <= 5'h00;
      lim_q <= 14'h0000;
      base_q <= 14'h0000;
      off_q <= 4'h0;
      aoff_q <= 2'h0;
      hit_q <= 1'b0;
      hit_addr_q <= '0;
      cnt_set_q <= 1'b0;
      key_ready_q <= 1'b1;
      lookup_busy_q <= 1'b0;
      res_valid_q <= 1'b0;
      res_last_q <= 1'b0;
      res_hit_q <= 1'b0;
      res_addr_q <= '0;
      res_action_q <= '0;
    end else begin
      cnt_set_q <= 1'b0;
      res_valid_q <= 1'b0;
      res_last_q <= 1'b0;
      case (state_q)
        CRL_IDLE: begin
          if (link.key_valid && key_ready_q) begin
            key_q <= link.key_words;
            szl_q <= link.key_szl;
            lk_q <= link.key_lookup;
            def_q <= link.key_default;
            lim_q <= {1'b0, link.blocks, 10'h000};
            base_q <= 14'h0000;
            off_q <= 4'h0;
            key_ready_q <= 1'b0;
            lookup_busy_q <= 1'b1;
            state_q <= CRL_CMP;
          end
        end
        CRL_CMP: begin
          // Candidates step by the span, so only aligned starts are tried
          if (nxt_base > lim_q) begin
            hit_q <= 1'b0;
            hit_addr_q <= def_addr;
            cnt_set_q <= 1'b1;
            aoff_q <= 2'h0;
            state_q <= CRL_ACT;
          end else if (!ent_hit) begin
            off_q <= 4'h0;
            base_q <= nxt_base;
          end else if ({10'h000, off_q} == span - 14'h0001) begin
            // Lowest address matches first, giving it priority
            hit_q <= 1'b1;
            hit_addr_q <= base_q[`CRL_ADDR_W-1:0];
            cnt_set_q <= 1'b1;
            aoff_q <= 2'h0;
            state_q <= CRL_ACT;
          end else begin
            off_q <= off_q + 4'h1;
          end
        end
        CRL_ACT: begin
          res_valid_q <= 1'b1;
          res_hit_q <= hit_q;
          res_addr_q <= hit_addr_q;
          res_action_q <= act_mem[act_addr] >> crl_atg_w(aoff_q, alen);
          res_last_q <= (aoff_q == alast);
          if (aoff_q == alast) begin
            key_ready_q <= 1'b1;
            lookup_busy_q <= 1'b0;
            state_q <= CRL_IDLE;
          end else begin
            aoff_q <= aoff_q + 2'h1;
          end
        end
        default: state_q <= CRL_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Link outputs
  // ------------------------------------------------------------
  assign link.key_ready = key_ready_q;
  assign link.res_valid = res_valid_q;
  assign link.res_last = res_last_q;
  assign link.res_hit = res_hit_q;
  assign link.res_addr = res_addr_q;
  assign link.res_action = res_action_q;
  assign link.rd_valid = rd_valid_q;
  assign link.rd_entry = rd_entry_q;
  assign link.rd_mask = rd_mask_q;
  assign link.rd_action = rd_action_q;
  assign link.rd_cnt = rd_cnt_q;

endmodule // crl_store

// ---- hdl/crl_driver.sv ----
// Programming and key-submitting end of the rule store link. It inserts
// type-group fields, zeroes their masks and refuses misplaced rules.
// Assumes the store end runs on the same mclk.
`include "crl_map.svh"

module crl_driver (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Link to the store
  crl_if.host link,
  // Configuration
  input wire logic [2:0] blocks_cfg,
  // Word write and read
  input wire logic u_wr_valid,
  input wire logic u_rd_valid,
  input wire crl_pkg::crl_kind_type u_wr_kind,
  input wire crl_pkg::crl_addr_type u_wr_start,
  input wire logic [3:0] u_wr_off,
  input wire logic [2:0] u_wr_szl,
  input wire crl_pkg::crl_act_word_type u_wr_data,
  input wire crl_pkg::crl_ent_word_type u_wr_mask,
  output logic u_wr_err_q,
  output logic u_rd_done_q,
  output crl_pkg::crl_ent_word_type u_rd_entry_q,
  output crl_pkg::crl_act_word_type u_rd_action_q,
  output logic u_rd_cnt_q,
  // Key submission
  input wire logic u_key_valid,
  input wire crl_pkg::crl_key_type u_key_words,
  input wire logic [2:0] u_key_szl,
  input wire logic [1:0] u_key_lookup,
  input wire logic [4:0] u_key_default,
  output logic u_key_ready_q,
  output logic u_key_err_q,
  // Results
  output logic u_res_valid_q,
  output logic u_res_last_q,
  output logic u_res_hit_q,
  output crl_pkg::crl_addr_type u_res_addr_q,
  output crl_pkg::crl_act_word_type u_res_action_q
);
  import crl_pkg::*;

  logic [4:0] span;
  crl_addr_type wr_addr;
  logic wr_ok, key_ok;
  logic [2:0] etw, atw;

  always_comb begin
    span = 5'h01 << u_wr_szl;
    wr_addr = u_wr_start + {9'h000, u_wr_off};
    etw = crl_etg_w(u_wr_off, u_wr_szl);
    atw = crl_atg_w(u_wr_off[1:0], u_wr_szl);
    // Misaligned starts and offsets beyond the span are refused
    wr_ok = (u_wr_szl <= `CRL_MAX_ENT_LOG) && ({1'b0, u_wr_off} < span)
      && ((u_wr_start[4:0] & (span - 5'h01)) == 5'h00);
    if (u_wr_kind == CRL_ACTION) wr_ok = wr_ok && (u_wr_szl <= `CRL_MAX_ACT_LOG);
    key_ok = (u_key_lookup < `CRL_LOOKUPS) && (u_key_default < `CRL_DEF_RULES)
      && (u_key_szl <= `CRL_MAX_ENT_LOG);
  end

  // ------------------------------------------------------------
  // Programming path
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.blocks <= 3'h0;
      link.prog_valid <= 1'b0;
      link.prog_rd <= 1'b0;
      link.prog_kind <= CRL_ENTRY;
      link.prog_addr <= '0;
      link.prog_entry <= '0;
      link.prog_mask <= '0;
      link.prog_action <= '0;
      link.prog_cnt <= 1'b0;
      u_wr_err_q <= 1'b0;
    end else begin
      link.blocks <= blocks_cfg;
      link.prog_valid <= u_wr_valid && wr_ok;
      link.prog_rd <= u_rd_valid && !u_wr_valid;
      u_wr_err_q <= u_wr_valid && !wr_ok;
      if (u_wr_valid || u_rd_valid) begin
        link.prog_kind <= u_wr_kind;
        link.prog_addr <= wr_addr;
        link.prog_entry <= (u_wr_data[`CRL_ENT_W-1:0] << etw)
          | {31'h0, crl_tg_val(u_wr_off, u_wr_szl)};
        link.prog_mask <= u_wr_mask << etw;
        link.prog_action <= (u_wr_data << atw)
          | {65'h0, crl_tg_val(u_wr_off, u_wr_szl)};
        link.prog_cnt <= u_wr_data[0];
      end
    end
  end

  // ------------------------------------------------------------
  // Key and result path
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.key_valid <= 1'b0;
      link.key_words <= '0;
      link.key_szl <= 3'h0;
      link.key_lookup <= 2'h0;
      link.key_default <= 5'h00;
      u_key_ready_q <= 1'b1;
      u_key_err_q <= 1'b0;
    end else begin
      u_key_err_q <= u_key_valid && u_key_ready_q && !key_ok;
      if (u_key_valid && u_key_ready_q && key_ok) begin
        link.key_valid <= 1'b1;
        link.key_words <= u_key_words;
        link.key_szl <= u_key_szl;
        link.key_lookup <= u_key_lookup;
        link.key_default <= u_key_default;
        u_key_ready_q <= 1'b0;
      end else if (link.key_valid && link.key_ready) begin
        link.key_valid <= 1'b0;
        u_key_ready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      u_rd_done_q <= 1'b0;
      u_rd_entry_q <= '0;
      u_rd_action_q <= '0;
      u_rd_cnt_q <= 1'b0;
      u_res_valid_q <= 1'b0;
      u_res_last_q <= 1'b0;
      u_res_hit_q <= 1'b0;
      u_res_addr_q <= '0;
      u_res_action_q <= '0;
    end else begin
      u_rd_done_q <= link.rd_valid;
      u_rd_entry_q <= link.rd_entry;
      u_rd_action_q <= link.rd_action;
      u_rd_cnt_q <= link.rd_cnt;
      u_res_valid_q <= link.res_valid;
      u_res_last_q <= link.res_last;
      u_res_hit_q <= link.res_hit;
      u_res_addr_q <= link.res_addr;
      u_res_action_q <= link.res_action;
    end
  end

endmodule // crl_driver

// ---- test/crl_props.sv ----
// Checker of the rule store link: watches the interface signals only.
// Assumes one clock mclk and the asynchronous active-low reset arst_n.
module crl_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Link signals
  input wire logic [2:0] blocks,
  input wire logic prog_valid,
  input wire logic prog_rd,
  input wire crl_pkg::crl_kind_type prog_kind,
  input wire crl_pkg::crl_ent_word_type prog_mask,
  input wire logic rd_valid,
  input wire logic key_valid,
  input wire logic key_ready,
  input wire logic [1:0] key_lookup,
  input wire logic [4:0] key_default,
  input wire logic res_valid,
  input wire logic res_last,
  input wire logic res_hit,
  input wire crl_pkg::crl_addr_type res_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import crl_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  logic take;
  crl_addr_type def_addr_q;
  assign take = key_valid && key_ready;

  // Default rule of the key in flight
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      def_addr_q <= 13'h0;
    end else if (take) begin
      def_addr_q <= (key_lookup == 2'h0 ? 13'h1800 : key_lookup == 2'h1 ? 13'h19e0 : 13'h1bc0)
                    + {4'h0, key_default, 4'h0};
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_rd_answer;
    prog_rd |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

  property p_accept_gap;
    take |=> !key_ready && !res_valid;
  endproperty
  a_accept_gap: assert property (p_accept_gap) else $error("result too early");

  property p_empty_default;
    take && blocks == 3'h0 |-> ##[2:8] (res_valid && !res_hit);
  endproperty
  a_empty_default: assert property (p_empty_default) else $error("no default hit");

  property p_no_hit_empty;
    res_valid && blocks == 3'h0 |-> !res_hit;
  endproperty
  a_no_hit_empty: assert property (p_no_hit_empty) else $error("hit without blocks");

  property p_def_addr;
    res_valid && !res_hit |-> res_addr == def_addr_q;
  endproperty
  a_def_addr: assert property (p_def_addr) else $error("wrong default address");

  property p_hit_limit;
    res_valid && res_hit |-> res_addr < {blocks, 10'h0};
  endproperty
  a_hit_limit: assert property (p_hit_limit) else $error("hit beyond blocks");

  property p_ready_back;
    res_valid && res_last |-> key_ready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("not ready after result");

  property p_mask_tg;
    prog_valid && prog_kind == CRL_ENTRY |-> !prog_mask[0];
  endproperty
  a_mask_tg: assert property (p_mask_tg) else $error("type-group bit masked");

  property p_last_in_word;
    res_last |-> res_valid;
  endproperty
  a_last_in_word: assert property (p_last_in_word) else $error("last without word");

  c_empty: cover property (take && blocks == 3'h0);
  c_hit: cover property (res_valid && res_hit);
  c_multi: cover property (res_valid && !res_last);
endmodule // crl_props

// ---- test/test_classifier_rule_layout.sv ----
// Self-checking bench: driver end and store end joined by the link interface.
// Assumes the design files of hdl/ are compiled first.
module test_classifier_rule_layout;
  timeunit 1ns;
  timeprecision 1ps;
  import crl_pkg::*;

  logic mclk, arst_n, u_wr_valid, u_rd_valid, u_key_valid;
  logic u_wr_err_q, u_rd_done_q, u_rd_cnt_q, u_key_ready_q, u_key_err_q, h, er, c;
  logic u_res_valid_q, u_res_last_q, u_res_hit_q, lookup_busy_q;
  logic [2:0] blocks_cfg, u_wr_szl, u_key_szl;
  logic [3:0] u_wr_off;
  logic [1:0] u_key_lookup;
  logic [4:0] u_key_default;
  crl_kind_type u_wr_kind;
  crl_addr_type u_wr_start, u_res_addr_q, ad, ea;
  crl_act_word_type u_wr_data, u_rd_action_q, u_res_action_q, act;
  crl_ent_word_type u_wr_mask, u_rd_entry_q;
  crl_key_type u_key_words;
  crl_addr_type base [3] = '{13'h1800, 13'h19e0, 13'h1bc0};
  int mismatches = 0, checks_done = 0, cycles = 0, nw;

  crl_if link ();
  crl_store crl_store_inst (.mclk, .arst_n, .link(link.dev), .lookup_busy_q);
  crl_driver crl_driver_inst (.mclk, .arst_n, .link(link.host), .blocks_cfg, .u_wr_valid,
    .u_rd_valid, .u_wr_kind, .u_wr_start, .u_wr_off, .u_wr_szl, .u_wr_data, .u_wr_mask,
    .u_wr_err_q, .u_rd_done_q, .u_rd_entry_q, .u_rd_action_q, .u_rd_cnt_q, .u_key_valid,
    .u_key_words, .u_key_szl, .u_key_lookup, .u_key_default, .u_key_ready_q, .u_key_err_q,
    .u_res_valid_q, .u_res_last_q, .u_res_hit_q, .u_res_addr_q, .u_res_action_q);
  crl_props crl_props_inst (.mclk, .arst_n, .blocks(link.blocks),
    .prog_valid(link.prog_valid), .prog_rd(link.prog_rd), .prog_kind(link.prog_kind),
    .prog_mask(link.prog_mask), .rd_valid(link.rd_valid), .key_valid(link.key_valid),
    .key_ready(link.key_ready), .key_lookup(link.key_lookup), .key_default(link.key_default),
    .res_valid(link.res_valid), .res_last(link.res_last), .res_hit(link.res_hit),
    .res_addr(link.res_addr));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [69:0] seen, input logic [69:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Type-group width, apart from the design's helpers
  function automatic int tgw(input int off, input int szl, input bit act);
    if (off == 0) return szl + 1;
    if (off % 2 == 1) return 1;
    if (act || off % 4 == 2) return 2;
    if (off % 8 == 4) return 3;
    return 4;
  endfunction

  task automatic wr(input crl_kind_type k, input int st, input int off, input int szl,
                    input crl_act_word_type d, input crl_ent_word_type m, input bit err);
    crl_ent_word_type e, em;
    crl_act_word_type a;
    crl_addr_type pa;
    int w;
    w = tgw(off, szl, k == CRL_ACTION);
    e = (d[35:0] << w) | ((off == 0) ? (36'h1 << szl) : 36'h0);
    em = m << w;
    a = (d << w) | ((off == 0) ? (70'h1 << szl) : 70'h0);
    pa = 13'(st + off);
    @(negedge mclk);
    u_wr_valid = 1'b1;
    u_wr_kind = k;
    u_wr_start = 13'(st);
    u_wr_off = 4'(off);
    u_wr_szl = 3'(szl);
    u_wr_data = d;
    u_wr_mask = m;
    @(negedge mclk);
    u_wr_valid = 1'b0;
    chk(70'(u_wr_err_q), 70'(err));
    chk(70'(link.prog_valid), 70'(!err));
    if (!err) begin
      chk(70'(link.prog_addr), 70'(pa));
      if (k == CRL_ENTRY) chk(70'(link.prog_entry), 70'(e));
      if (k == CRL_ENTRY) chk(70'(link.prog_mask), 70'(em));
      if (k == CRL_ACTION) chk(link.prog_action, a);
      if (k == CRL_COUNTER) chk(70'(link.prog_cnt), 70'(d[0]));
    end
  endtask

  // Counter read: the answer lands three cycles after the request
  task automatic rdcnt(input int at, output logic c);
    @(negedge mclk);
    u_rd_valid = 1'b1;
    u_wr_kind = CRL_COUNTER;
    u_wr_start = 13'(at);
    u_wr_off = 4'h0;
    @(negedge mclk);
    u_rd_valid = 1'b0;
    repeat (2) @(negedge mclk);
    c = u_rd_done_q ? u_rd_cnt_q : 1'bx;
  endtask

  task automatic key(input int szl, input int lk, input int dn, input crl_ent_word_type k0,
                     input crl_ent_word_type k1, output logic h, output crl_addr_type ad,
                     output crl_act_word_type act, output int nw, output logic er);
    nw = 0;
    er = 1'b0;
    @(negedge mclk);
    for (int i = 0; i < 20 && u_key_ready_q !== 1'b1; i++) @(negedge mclk);
    u_key_valid = 1'b1;
    u_key_szl = 3'(szl);
    u_key_lookup = 2'(lk);
    u_key_default = 5'(dn);
    u_key_words = {504'h0, k1, k0};
    @(negedge mclk);
    u_key_valid = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      if (i == 1) chk(70'(lookup_busy_q), 70'h1);
      er |= u_key_err_q;
      if (u_res_valid_q) begin
        if (nw == 0) begin
          h = u_res_hit_q;
          ad = u_res_addr_q;
          act = u_res_action_q;
        end
        nw++;
        if (u_res_last_q) break;
      end
      if (er) break;
      @(negedge mclk);
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_type_groups;
    for (int o = 15; o >= 0; o--) wr(CRL_ENTRY, 16, o, 4, ~70'h0, ~36'h0, 1'b0);
    for (int o = 3; o >= 0; o--) wr(CRL_ACTION, 16, o, 2, ~70'h0, 36'h0, 1'b0);
    for (int s = 0; s < 4; s++) wr(CRL_ENTRY, 32, 0, s, ~70'h0, ~36'h0, 1'b0);
    for (int s = 0; s < 2; s++) wr(CRL_ACTION, 32, 0, s, ~70'h0, 36'h0, 1'b0);
    $display("type groups done");
  endtask

  task automatic t_refusals;
    wr(CRL_ENTRY, 1, 0, 1, 70'h0, 36'h0, 1'b1);
    wr(CRL_ENTRY, 8, 2, 1, 70'h0, 36'h0, 1'b1);
    wr(CRL_ACTION, 8, 0, 3, 70'h0, 36'h0, 1'b1);
    wr(CRL_ENTRY, 0, 0, 5, 70'h0, 36'h0, 1'b1);
    key(0, 3, 0, 36'h1, 36'h0, h, ad, act, nw, er);
    chk(70'(er), 70'h1);
    key(0, 0, 30, 36'h1, 36'h0, h, ad, act, nw, er);
    chk(70'(er), 70'h1);
    $display("refusals done");
  endtask

  task automatic t_defaults;
    blocks_cfg = 3'h0;
    for (int lk = 0; lk < 3; lk++) begin
      for (int n = 0; n < 30; n += 29) begin
        ea = base[lk] + 13'(n * 16);
        wr(CRL_ACTION, ea, 0, 0, 70'(lk * 64 + n + 1), 36'h0, 1'b0);
        wr(CRL_COUNTER, ea, 0, 0, 70'h0, 36'h0, 1'b0);
        wr(CRL_COUNTER, ea + 1, 0, 0, 70'h0, 36'h0, 1'b0);
        key(0, lk, n, 36'h1, 36'h0, h, ad, act, nw, er);
        chk(70'(h), 70'h0);
        chk(70'(ad), 70'(ea));
        chk(act, 70'(lk * 64 + n + 1));
        chk(70'(nw), 70'h1);
        rdcnt(ea, c);
        chk(70'(c), 70'h1);
        chk(u_rd_action_q, 70'((lk * 64 + n + 1) * 2 + 1));
        rdcnt(ea + 1, c);
        chk(70'(c), 70'h0);
      end
    end
    $display("defaults done");
  endtask

  task automatic t_hits;
    blocks_cfg = 3'h1;
    // Memory is not reset, so every scanned address gets a non-matching entry
    for (int a = 0; a < 1024; a++) wr(CRL_ENTRY, a, 0, 0, 70'h0, 36'h0, 1'b0);
    wr(CRL_ENTRY, 1024, 0, 0, 70'h5a5a5a5, 36'h0, 1'b0);
    wr(CRL_ACTION, 6192, 0, 0, 70'h3c, 36'h0, 1'b0);
    key(0, 0, 3, 36'h5a5a5a5, 36'h0, h, ad, act, nw, er);
    chk(70'(h), 70'h0);
    chk(70'(ad), 70'd6192);
    for (int s = 6; s <= 10; s += 4) begin
      wr(CRL_ENTRY, s, 1, 1, 70'hc3c3c3, 36'h0, 1'b0);
      wr(CRL_ENTRY, s, 0, 1, 70'h5a5a5a5, 36'h0, 1'b0);
    end
    wr(CRL_ACTION, 6, 1, 1, 70'h77, 36'h0, 1'b0);
    wr(CRL_ACTION, 6, 0, 1, 70'h55, 36'h0, 1'b0);
    wr(CRL_COUNTER, 6, 0, 0, 70'h0, 36'h0, 1'b0);
    wr(CRL_COUNTER, 7, 0, 0, 70'h0, 36'h0, 1'b0);
    for (int r = 0; r < 2; r++) begin
      key(1, 0, 3, 36'h5a5a5a5, 36'hc3c3c3, h, ad, act, nw, er);
      chk(70'(h), 70'h1);
      chk(70'(ad), 70'h6);
      chk(act, 70'h55);
      chk(70'(nw), 70'h2);
      rdcnt(6, c);
      chk(70'(c), 70'h1);
      chk(70'(u_rd_entry_q), 70'h16969696);
      rdcnt(7, c);
      chk(70'(c), 70'h0);
    end
    $display("hits done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Ceiling far above the ~3300 cycles needed
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      stop_test;
    end
  end

  initial begin
    arst_n = 1'b0;
    {blocks_cfg, u_wr_valid, u_rd_valid, u_key_valid, u_wr_start, u_wr_off, u_wr_szl} = '0;
    {u_wr_data, u_wr_mask, u_key_words, u_key_szl, u_key_lookup, u_key_default} = '0;
    u_wr_kind = CRL_ENTRY;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    t_type_groups;
    t_refusals;
    t_defaults;
    t_hits;
    stop_test;
  end
endmodule // test_classifier_rule_layout
